//--- rtl/udr_defines.vh
`ifndef UDR_DEFINES_VH
`define UDR_DEFINES_VH

// ----------------------------------------------------------------
// Channel windows
// ----------------------------------------------------------------
`define UDR_CH0_BASE      4'h0
`define UDR_CH1_BASE      4'h8
`define UDR_WIN_BYTES     8

// ----------------------------------------------------------------
// Window offsets
// ----------------------------------------------------------------
`define UDR_OFF_DATA      3'h0
`define UDR_OFF_IEN       3'h1
`define UDR_OFF_ISTAT     3'h2
`define UDR_OFF_LCTL      3'h3
`define UDR_OFF_MCTL      3'h4
`define UDR_OFF_LSTAT     3'h5
`define UDR_OFF_MSTAT     3'h6
`define UDR_OFF_SFN       3'h7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define UDR_LCTL_DIV_BIT  7
`define UDR_IEN_RXRDY     0
`define UDR_IEN_TXEMP     1
`define UDR_IEN_RXERR     2
`define UDR_IEN_MODEM     3
`define UDR_IEN_FLOW      4
`define UDR_IEN_RTSDTR    5
`define UDR_IEN_CTSDSR    6
`define UDR_SRC_RXERR     0
`define UDR_SRC_RXTMO     1
`define UDR_SRC_TXEMP     2
`define UDR_SRC_MODEM     3
`define UDR_SRC_FLOW      4
`define UDR_SRC_RTSDTR    5
`define UDR_SRC_CTSDSR    6

// ----------------------------------------------------------------
// Status codes, reset values and enable mask
// ----------------------------------------------------------------
`define UDR_IS_NONE       8'hc1
`define UDR_IS_RXERR      8'hc6
`define UDR_IS_RXRDY      8'hc4
`define UDR_IS_RXTMO      8'hcc
`define UDR_IS_TXEMP      8'hc2
`define UDR_IS_MODEM      8'hc0
`define UDR_IS_FLOW       8'hd0
`define UDR_IS_RTSCTS     8'he0
`define UDR_RST_ZERO      8'h00
`define UDR_RST_LCTL      8'h03
`define UDR_IEN_MASK      8'h7f

`endif

//--- rtl/udr_uart_regs.v
// Contract
// RULE1: each channel has eight-byte register window
// RULE2: channel zero at base, one at eight
// RULE3: offset zero read returns received character
// RULE4: offset zero write loads transmit character
// RULE5: offset two: read status, write fifo control
// RULE6: offsets three to seven decode fixed
// RULE7: divisor bit remaps offsets zero to two
// RULE8: enable bit0 gates receive data ready
// RULE9: enable bit1 gates transmit empty
// RULE10: enable bit2 gates receive line status
// RULE11: enable bit3 gates modem status change
// RULE12: enable bit4 gates flow control character
// RULE13: enable bit5 gates rts/dtr change
// RULE14: enable bit6 gates cts/dsr change
// RULE15: status bit0 low means interrupt pending
// RULE16: idle and reset status reads c1
// RULE17: status shows highest priority pending source
// RULE18: request follows any enabled pending source
`timescale 1ns/1ns
`include "udr_defines.vh"

module udr_uart_regs (
   input  wire        clock,
   input  wire        resetn,
   input  wire [3:0]  io_addr,
   input  wire        io_rd,
   input  wire        io_wr,
   input  wire [7:0]  io_wdata,
   output reg  [7:0]  io_rdata,
   input  wire [1:0]  rx_load,
   input  wire [15:0] rx_data,
   input  wire [13:0] irq_src,
   input  wire [15:0] line_status_in,
   input  wire [15:0] modem_status_in,
   output reg  [1:0]  tx_load,
   output reg  [15:0] tx_holding_reg,
   output reg  [1:0]  fifo_load,
   output reg  [15:0] fifo_control_reg,
   output reg  [15:0] line_control_reg,
   output reg  [15:0] modem_control_reg,
   output reg  [15:0] special_function_reg,
   output reg  [15:0] divisor_low_reg,
   output reg  [15:0] divisor_high_reg,
   output reg  [15:0] sample_clock_reg,
   output reg  [15:0] irq_enable_reg,
   output reg  [15:0] irq_status_reg,
   output reg  [1:0]  irq_req
);

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   // Codes listed highest first; a source only counts when enabled.
   function [7:0] prio_code;
      input [7:0] ien;
      input [6:0] src;
      input       rdy;
      begin
         if (ien[`UDR_IEN_RXERR] && src[`UDR_SRC_RXERR])    // see RULE10
            prio_code = `UDR_IS_RXERR;                     // see RULE17
         else if (ien[`UDR_IEN_RXRDY] && rdy)               // see RULE8
            prio_code = `UDR_IS_RXRDY;
         else if (ien[`UDR_IEN_RXRDY] && src[`UDR_SRC_RXTMO])
            prio_code = `UDR_IS_RXTMO;
         else if (ien[`UDR_IEN_TXEMP] && src[`UDR_SRC_TXEMP]) // see RULE9
            prio_code = `UDR_IS_TXEMP;
         else if (ien[`UDR_IEN_MODEM] && src[`UDR_SRC_MODEM]) // see RULE11
            prio_code = `UDR_IS_MODEM;
         else if (ien[`UDR_IEN_FLOW] && src[`UDR_SRC_FLOW])   // see RULE12
            prio_code = `UDR_IS_FLOW;
         else if ((ien[`UDR_IEN_RTSDTR] && src[`UDR_SRC_RTSDTR]) ||
                  (ien[`UDR_IEN_CTSDSR] && src[`UDR_SRC_CTSDSR]))
            prio_code = `UDR_IS_RTSCTS;               // see RULE13 RULE14
         else
            prio_code = `UDR_IS_NONE;                      // see RULE16
      end
   endfunction

   // -------------------------------------------------------------
   // Decode
   // -------------------------------------------------------------
   // Address bit 3 picks the channel window, the low three the slot.
   wire [3:0] ch1_base = `UDR_CH1_BASE;
   wire       sel_ch   = (io_addr[3] == ch1_base[3]);       // see RULE2
   wire [2:0] sel_off  = io_addr[2:0];                      // see RULE1

   reg  [15:0] rx_holding_reg;
   reg  [1:0]  rx_ready_reg;

   reg  [7:0]  rd_value;

   integer c;

   // -------------------------------------------------------------
   // Slot decode
   // -------------------------------------------------------------
   // True when a strobe is up and the slot matches the one wanted.
   function slot_hit;
      input       strobe;
      input [2:0] off;
      input [2:0] want;
      begin
         slot_hit = strobe && (off == want);
      end
   endfunction

   // The channel bit picks both the byte lane and the divisor bit.
   wire [3:0] sel_base = {sel_ch, 3'b000};
   wire [3:0] div_idx  = {sel_ch, 3'd`UDR_LCTL_DIV_BIT};
   wire       sel_div  = line_control_reg[div_idx];         // see RULE7

   // -------------------------------------------------------------
   // Access strobes
   // -------------------------------------------------------------
   // One strobe per register keeps every process below small.
   wire wr_data = slot_hit(io_wr, sel_off, `UDR_OFF_DATA)  && !sel_div;
   wire wr_ien  = slot_hit(io_wr, sel_off, `UDR_OFF_IEN)   && !sel_div;
   wire wr_fifo = slot_hit(io_wr, sel_off, `UDR_OFF_ISTAT) && !sel_div;
   wire wr_dll  = slot_hit(io_wr, sel_off, `UDR_OFF_DATA)  && sel_div;
   wire wr_dlh  = slot_hit(io_wr, sel_off, `UDR_OFF_IEN)   && sel_div;
   wire wr_scr  = slot_hit(io_wr, sel_off, `UDR_OFF_ISTAT) && sel_div;
   wire wr_lctl = slot_hit(io_wr, sel_off, `UDR_OFF_LCTL);
   wire wr_mctl = slot_hit(io_wr, sel_off, `UDR_OFF_MCTL);
   wire wr_sfn  = slot_hit(io_wr, sel_off, `UDR_OFF_SFN);
   wire rd_data = slot_hit(io_rd, sel_off, `UDR_OFF_DATA)  && !sel_div;

   // -------------------------------------------------------------
   // Transmit holding
   // -------------------------------------------------------------
   always @(posedge clock) begin
      if (!resetn) begin
         tx_holding_reg <= {2{`UDR_RST_ZERO}};
         tx_load        <= 2'b00;
      end else begin
         tx_load <= 2'b00;
         if (wr_data) begin                                 // see RULE4
            tx_holding_reg[sel_base +: 8] <= io_wdata;
            tx_load[sel_ch]               <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------
   // FIFO control
   // -------------------------------------------------------------
   // Write only; the load pulse tells the FIFO logic to act on it.
   always @(posedge clock) begin
      if (!resetn) begin
         fifo_control_reg <= {2{`UDR_RST_ZERO}};
         fifo_load        <= 2'b00;
      end else begin
         fifo_load <= 2'b00;
         if (wr_fifo) begin                                 // see RULE5
            fifo_control_reg[sel_base +: 8] <= io_wdata;
            fifo_load[sel_ch]               <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------
   // Interrupt enable
   // -------------------------------------------------------------
   // Bit 7 is reserved and is never stored, so it always reads 0.
   always @(posedge clock) begin
      if (!resetn) begin
         irq_enable_reg <= {2{`UDR_RST_ZERO}};
      end else begin
         if (wr_ien) begin                                  // see RULE7
            irq_enable_reg[sel_base +: 8] <= io_wdata & `UDR_IEN_MASK;
         end
      end
   end

   // -------------------------------------------------------------
   // Divisor and sample clock
   // -------------------------------------------------------------
   // Only reachable while the divisor bit of the channel is set.
   always @(posedge clock) begin
      if (!resetn) begin
         divisor_low_reg  <= {2{`UDR_RST_ZERO}};
         divisor_high_reg <= {2{`UDR_RST_ZERO}};
         sample_clock_reg <= {2{`UDR_RST_ZERO}};
      end else begin
         if (wr_dll) begin                                  // see RULE7
            divisor_low_reg[sel_base +: 8] <= io_wdata;
         end
         if (wr_dlh) begin
            divisor_high_reg[sel_base +: 8] <= io_wdata;
         end
         if (wr_scr) begin
            sample_clock_reg[sel_base +: 8] <= io_wdata;
         end
      end
   end

   // -------------------------------------------------------------
   // Line, modem and special function control
   // -------------------------------------------------------------
   always @(posedge clock) begin
      if (!resetn) begin
         line_control_reg     <= {2{`UDR_RST_LCTL}};
         modem_control_reg    <= {2{`UDR_RST_ZERO}};
         special_function_reg <= {2{`UDR_RST_ZERO}};
      end else begin
         if (wr_lctl) begin                                 // see RULE6
            line_control_reg[sel_base +: 8] <= io_wdata;
         end
         if (wr_mctl) begin
            modem_control_reg[sel_base +: 8] <= io_wdata;
         end
         if (wr_sfn) begin
            special_function_reg[sel_base +: 8] <= io_wdata;
         end
      end
   end

   // -------------------------------------------------------------
   // Receive holding
   // -------------------------------------------------------------
   always @(posedge clock) begin
      if (!resetn) begin
         rx_holding_reg <= {2{`UDR_RST_ZERO}};
         rx_ready_reg   <= 2'b00;
      end else begin
         for (c = 0; c < 2; c = c + 1) begin
            // A new character beats a read clearing the ready flag.
            if (rd_data && sel_ch == c) begin               // see RULE3
               rx_ready_reg[c] <= 1'b0;
            end
            if (rx_load[c]) begin
               rx_holding_reg[c*8 +: 8] <= rx_data[c*8 +: 8];
               rx_ready_reg[c]          <= 1'b1;
            end
         end
      end
   end

   // -------------------------------------------------------------
   // Interrupt status and request
   // -------------------------------------------------------------
   // Both follow the sources one cycle late, so a status read and
   // the request line always agree with each other.
   always @(posedge clock) begin
      if (!resetn) begin
         irq_status_reg <= {2{`UDR_IS_NONE}};               // see RULE16
         irq_req        <= 2'b00;
      end else begin
         for (c = 0; c < 2; c = c + 1) begin
            irq_status_reg[c*8 +: 8] <=
               prio_code(irq_enable_reg[c*8 +: 8], irq_src[c*7 +: 7],
                         rx_ready_reg[c]);                  // see RULE15
            irq_req[c] <=
               (prio_code(irq_enable_reg[c*8 +: 8], irq_src[c*7 +: 7],
                          rx_ready_reg[c]) != `UDR_IS_NONE); // see RULE18
         end
      end
   end

   // -------------------------------------------------------------
   // Read multiplexer
   // -------------------------------------------------------------
   always @* begin
      rd_value = `UDR_RST_ZERO;
      case (sel_off)
         `UDR_OFF_DATA: begin                         // see RULE3 RULE7
            if (sel_div) begin
               rd_value = divisor_low_reg[sel_base +: 8];
            end else begin
               rd_value = rx_holding_reg[sel_base +: 8];
            end
         end
         `UDR_OFF_IEN: begin
            if (sel_div) begin
               rd_value = divisor_high_reg[sel_base +: 8];
            end else begin
               rd_value = irq_enable_reg[sel_base +: 8];
            end
         end
         `UDR_OFF_ISTAT: begin                              // see RULE5
            if (sel_div) begin
               rd_value = sample_clock_reg[sel_base +: 8];
            end else begin
               rd_value = irq_status_reg[sel_base +: 8];
            end
         end
         `UDR_OFF_LCTL:  rd_value = line_control_reg[sel_base +: 8];
         `UDR_OFF_MCTL:  rd_value = modem_control_reg[sel_base +: 8];
         `UDR_OFF_LSTAT: rd_value = line_status_in[sel_base +: 8];
         `UDR_OFF_MSTAT: rd_value = modem_status_in[sel_base +: 8];
         `UDR_OFF_SFN:   rd_value = special_function_reg[sel_base +: 8];
         default:        rd_value = `UDR_RST_ZERO;
      endcase
   end

   // -------------------------------------------------------------
   // Read data
   // -------------------------------------------------------------
   // Held until the next read so a slow host can pick it up late.
   always @(posedge clock) begin
      if (!resetn) begin
         io_rdata <= `UDR_RST_ZERO;
      end else begin
         if (io_rd) begin
            io_rdata <= rd_value;
         end
      end
   end

endmodule

//--- tb/udr_uart_sva.sv
`timescale 1ns/1ns
module udr_uart_sva (
   input wire        clock, resetn, io_rd, io_wr,
   input wire [3:0]  io_addr,
   input wire [7:0]  io_wdata, io_rdata,
   input wire [13:0] irq_src,
   input wire [1:0]  tx_load, fifo_load, irq_req,
   input wire [15:0] tx_holding_reg, line_control_reg, divisor_low_reg,
   input wire [15:0] irq_enable_reg, irq_status_reg
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   wire       dl0 = line_control_reg[7];
   wire [7:0] st0 = irq_status_reg[7:0];
   chk_tx_pulse:
   assert property (io_wr && io_addr == 4'h0 && !dl0 |=> tx_load[0] &&
      tx_holding_reg[7:0] == $past(io_wdata) ##1 !tx_load[0])
      else $error("tx load wrong");
   chk_fifo_pulse:
   assert property (io_wr && io_addr == 4'h2 && !dl0 |=> fifo_load[0] &&
      !tx_load[0]) else $error("fifo load wrong");
   chk_div_low:
   assert property (io_wr && io_addr == 4'h0 && dl0 |=> !tx_load[0] &&
      divisor_low_reg[7:0] == $past(io_wdata)) else $error("divisor wrong");
   chk_ien_mask:
   assert property (io_wr && io_addr == 4'h1 && !dl0 |=>
      irq_enable_reg[7:0] == ($past(io_wdata) & 8'h7f))
      else $error("enable wrong");
   chk_idle_code:
   assert property (irq_enable_reg[7:0] == 8'h00 |=> st0 == 8'hc1 &&
      !irq_req[0]) else $error("idle code wrong");
   chk_rxerr_first:
   assert property (irq_enable_reg[2] && irq_src[0] |=> st0 == 8'hc6 &&
      irq_req[0]) else $error("rx error code wrong");
   chk_pend_lsb:
   assert property (irq_req[0] != st0[0]) else $error("pending bit wrong");
   chk_rd_status:
   assert property (io_rd && io_addr == 4'h2 && !dl0 |=>
      io_rdata == $past(st0)) else $error("status read wrong");
endmodule
bind udr_uart_regs udr_uart_sva u_udr_uart_sva (.clock, .resetn, .io_rd,
   .io_wr, .io_addr, .io_wdata, .io_rdata, .irq_src, .tx_load, .fifo_load,
   .irq_req, .tx_holding_reg, .line_control_reg, .divisor_low_reg,
   .irq_enable_reg, .irq_status_reg);

//--- tb/udr_host.sv
`timescale 1ns/1ns
module udr_host (
   input  wire       clock,
   input  wire [7:0] io_rdata,
   output reg  [3:0] io_addr,
   output reg        io_rd,
   output reg        io_wr,
   output reg  [7:0] io_wdata
);
   initial begin
      io_addr = 4'h0; io_rd = 1'h0; io_wr = 1'h0; io_wdata = 8'h00;
   end
   task wr(input [3:0] a, input [7:0] v);
      begin
         @(posedge clock);
         io_addr <= a; io_wdata <= v; io_wr <= 1'h1;
         @(posedge clock);
         io_wr <= 1'h0;
         io_wdata <= ~v; // A released bus must not keep showing its data.
         #1;
      end
   endtask
   task rd(input [3:0] a, output [7:0] v);
      begin
         @(posedge clock);
         io_addr <= a; io_rd <= 1'h1;
         @(posedge clock);
         io_rd <= 1'h0;
         #1 v = io_rdata;
      end
   endtask
endmodule

//--- tb/tb.sv
`timescale 1ns/1ns
module tb;
   localparam [55:0] CODES = 56'he0_e0d0_c0c2_ccc6;
   localparam [20:0] ENB   = 21'h1a_c642;
   reg         clock, resetn;
   reg  [1:0]  rx_load;
   reg  [15:0] rx_data, line_status_in, modem_status_in;
   reg  [13:0] irq_src;
   wire [3:0]  io_addr;
   wire        io_rd, io_wr;
   wire [7:0]  io_wdata, io_rdata;
   wire [1:0]  irq_req;
   wire [15:0] tx_holding_reg;
   integer     errors, cmp_count, cyc, i;
   reg  [7:0]  d;
   udr_uart_regs u_udr_uart_regs (.clock, .resetn, .io_addr, .io_rd, .io_wr,
      .io_wdata, .io_rdata, .rx_load, .rx_data, .irq_src, .line_status_in,
      .modem_status_in, .tx_load(), .tx_holding_reg, .fifo_load(),
      .fifo_control_reg(), .line_control_reg(), .modem_control_reg(),
      .special_function_reg(), .divisor_low_reg(), .divisor_high_reg(),
      .sample_clock_reg(), .irq_enable_reg(), .irq_status_reg(), .irq_req);
   udr_host u_udr_host (.clock, .io_rdata, .io_addr, .io_rd, .io_wr, .io_wdata);
   task chk(input string nm, input [7:0] e, input [7:0] g);
      begin
         cmp_count = cmp_count + 1;
         if (g !== e) begin
            errors = errors + 1;
            $display("ERROR %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task rdc(input [3:0] a, input [7:0] e);
      begin
         u_udr_host.rd(a, d);
         chk($sformatf("reg %h", a), e, d);
      end
   endtask
   task t_reset;
      for (i = 0; i < 16; i = i + 8) begin
         rdc(i[3:0] + 4'h2, 8'hc1);
         rdc(i[3:0] + 4'h1, 8'h00);
         rdc(i[3:0], 8'h00);
      end
      chk("irq_req", 8'h00, {6'h00, irq_req});
   endtask
   task t_map;
      begin
         rx_data <= 16'ha53c;
         @(posedge clock) rx_load <= 2'h3;
         @(posedge clock) rx_load <= 2'h0;
         rdc(4'h0, 8'h3c); rdc(4'h8, 8'ha5);
         u_udr_host.wr(4'h4, 8'h11); u_udr_host.wr(4'hc, 8'h22);
         u_udr_host.wr(4'h7, 8'h33); u_udr_host.wr(4'h5, 8'hff);
         rdc(4'h4, 8'h11); rdc(4'hc, 8'h22); rdc(4'h7, 8'h33);
         rdc(4'h5, 8'h61); rdc(4'he, 8'hb0);
      end
   endtask
   task t_div;
      begin
         u_udr_host.wr(4'h3, 8'h83); u_udr_host.wr(4'h0, 8'ha5);
         u_udr_host.wr(4'h1, 8'h5a); u_udr_host.wr(4'h2, 8'h3c);
         rdc(4'h0, 8'ha5); rdc(4'h1, 8'h5a); rdc(4'h2, 8'h3c);
         u_udr_host.wr(4'h3, 8'h03); rdc(4'h1, 8'h00);
         rdc(4'h2, 8'hc1); rdc(4'h3, 8'h03);
         chk("tx_holding", 8'h00, tx_holding_reg[7:0]);
      end
   endtask
   task t_tx;
      begin
         u_udr_host.wr(4'h0, 8'h55);
         chk("tx_holding", 8'h55, tx_holding_reg[7:0]);
         u_udr_host.wr(4'h8, 8'h66);
         chk("tx_holding", 8'h66, tx_holding_reg[15:8]);
         u_udr_host.wr(4'h2, 8'h07); rdc(4'h2, 8'hc1);
      end
   endtask
   task t_irq;
      begin
         for (i = 0; i < 7; i = i + 1) begin
            @(posedge clock) irq_src <= 14'h0001 << i;
            u_udr_host.wr(4'h1, 8'h00); rdc(4'h2, 8'hc1);
            u_udr_host.wr(4'h1, 8'h01 << ENB[3*i+:3]);
            rdc(4'h2, CODES[8*i+:8]);
            chk("irq_req", 8'h01, {7'h00, irq_req[0]});
         end
         @(posedge clock) irq_src <= 14'h007f;
         u_udr_host.wr(4'h1, 8'hff); rdc(4'h1, 8'h7f);
         rdc(4'h2, 8'hc6);
         @(posedge clock) irq_src <= 14'h007e;
         rdc(4'h2, 8'hcc);
         @(posedge clock) rx_load <= 2'h1;
         @(posedge clock) rx_load <= 2'h0;
         rdc(4'h2, 8'hc4);
         @(posedge clock) irq_src <= 14'h0000;
         u_udr_host.wr(4'h1, 8'h00); rdc(4'h2, 8'hc1);
         chk("irq_req", 8'h00, {6'h00, irq_req});
      end
   endtask
   task close_out;
      begin
         if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask
   initial begin
      clock = 1'h0;
      forever #50 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         errors = errors + 1;
         close_out;
      end
   end
   initial begin
      resetn = 1'h0; rx_load = 2'h0; rx_data = 16'h0000; irq_src = 14'h0000;
      line_status_in = 16'h6061; modem_status_in = 16'hb0f0;
      errors = 0; cmp_count = 0; cyc = 0;
      repeat (3) @(posedge clock);
      resetn <= 1'h1;
      t_reset; t_map; t_div; t_tx; t_irq;
      close_out;
   end
endmodule
